// file: common/rftx_pkg.sv
package rftx_pkg;

  // Register addresses seen on the host parallel port.
  localparam logic [5:0] ADDR_TX_PIN_CONTROL = 6'h11;
  localparam logic [5:0] ADDR_DRIVER_CONDUCTANCE = 6'h12;
  localparam logic [5:0] ADDR_FIXED_SETTING_A = 6'h13;
  localparam logic [5:0] ADDR_FIXED_SETTING_B = 6'h14;
  localparam logic [5:0] ADDR_PULSE_WIDTH = 6'h15;
  localparam logic [5:0] ADDR_FIXED_SETTING_C = 6'h16;
  localparam logic [5:0] ADDR_FIXED_SETTING_D = 6'h17;
  localparam logic [5:0] ADDR_RECEIVER_GAIN_CONTROL = 6'h19;
  localparam logic [5:0] ADDR_DECODER_BEHAVIOUR = 6'h1A;

  // Values after reset.
  localparam logic [7:0] RST_TX_PIN_CONTROL = 8'h58;
  localparam logic [7:0] RST_DRIVER_CONDUCTANCE = 8'h3F;
  localparam logic [7:0] RST_FIXED_SETTING_A = 8'h3F;
  localparam logic [7:0] RST_FIXED_SETTING_B = 8'h19;
  localparam logic [7:0] RST_PULSE_WIDTH = 8'h13;
  localparam logic [7:0] RST_FIXED_SETTING_C = 8'h00;
  localparam logic [7:0] RST_FIXED_SETTING_D = 8'h00;
  localparam logic [7:0] RST_RECEIVER_GAIN_CONTROL = 8'h73;
  localparam logic [7:0] RST_DECODER_BEHAVIOUR = 8'h08;

  // Field positions in the transmit pin control register.
  localparam int TXC_MOD_SEL_LSB = 5;
  localparam int TXC_DRV2_INVERT = 3;
  localparam int TXC_DRV2_UNMOD = 2;
  localparam int TXC_DRV2_RF_ON = 1;
  localparam int TXC_DRV1_RF_ON = 0;

  // Field positions in the conductance, gain and decoder registers.
  localparam int COND_VALUE_LSB = 0;
  localparam int GAIN_CODE_LSB = 0;
  localparam int DEC_MULTI_FRAME = 6;
  localparam int DEC_MASK_AFTER_COLL = 5;

  // Modulator input selector codes.
  typedef enum logic [1:0] {
    RFTX_MOD_LOW = 2'b00,
    RFTX_MOD_HIGH = 2'b01,
    RFTX_MOD_ENCODER = 2'b10,
    RFTX_MOD_EXT_PIN = 2'b11
  } rftx_mod_sel_t;

  // Receiver voltage gain in dB for each gain code.
  localparam logic [5:0] GAIN_DB_CODE0 = 6'h14;
  localparam logic [5:0] GAIN_DB_CODE1 = 6'h18;
  localparam logic [5:0] GAIN_DB_CODE2 = 6'h1F;
  localparam logic [5:0] GAIN_DB_CODE3 = 6'h23;

  // Pulse length is this many device clock periods per width step.
  localparam int PULSE_CLKS_PER_STEP = 2;

  // Receiver activity states.
  typedef enum logic [0:0] {
    RFTX_RX_IDLE = 1'b0,
    RFTX_RX_ACTIVE = 1'b1
  } rftx_rx_state_t;

endpackage

// file: core/rftx_pulse_gen.sv
`timescale 1ns/100ps
`default_nettype none

// Modulation pulse generator: a rising edge of the modulator input starts
// one pulse whose length in clock periods is two times the width plus one.
module rftx_pulse_gen #(
  parameter int WIDTH_W = 8 // Width of the pulse width value.
) (
  input wire logic sys_clk, // Device clock.
  input wire logic rst, // Asynchronous reset, active high.
  input wire logic mod_level, // Modulator input level.
  input wire logic [WIDTH_W-1:0] width_value, // Pulse width value.
  output logic pulse // High while a pulse is running.
);

  // The counter must hold two times the largest width plus one, minus one.
  localparam int CNT_W = WIDTH_W + 1;

  // Refuse widths the counter layout was not sized for.
  if (WIDTH_W < 1 || WIDTH_W > 16)
  begin : g_width_check
    $error("rftx_pulse_gen: WIDTH_W must be 1 to 16");
  end

  logic prev_r; // Modulator level one cycle ago.
  logic prev_nxt;
  logic pulse_r; // Pulse running.
  logic pulse_nxt;
  logic [CNT_W-1:0] cnt_r; // Cycles left after this one.
  logic [CNT_W-1:0] cnt_nxt;

  // Edges during a pulse are ignored, so a host that reprograms the
  // source mid-pulse never cuts or stretches a pulse.
  always_comb
  begin
    prev_nxt = mod_level;
    pulse_nxt = pulse_r;
    cnt_nxt = cnt_r;
    if (pulse_r)
    begin
      // Count down; the last cycle is the one where the count is zero.
      if (cnt_r == '0)
        pulse_nxt = 1'b0;
      else
        cnt_nxt = cnt_r - 1'b1;
    end
    else if (mod_level && !prev_r)
    begin
      // Load 2*(w+1)-1 for a pulse of 2*(w+1) cycles.
      pulse_nxt = 1'b1;
      cnt_nxt = CNT_W'(rftx_pkg::PULSE_CLKS_PER_STEP)
        * ({1'b0, width_value} + 1'b1) - 1'b1;
    end
  end

  // Register stage.
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      prev_r <= 1'b0;
      pulse_r <= 1'b0;
      cnt_r <= '0;
    end
    else
    begin
      prev_r <= prev_nxt;
      pulse_r <= pulse_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  assign pulse = pulse_r;

endmodule

`default_nettype wire

// file: core/rftx_regs.sv
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// - Two-bit selector picks modulator input source.
// - Invert bit inverts carrier on driver two.
// - Unmodulated bit sends plain carrier, driver two.
// - Driver two enable: modulated carrier, else constant.
// - Driver one enable: modulated carrier, else constant.
// - Low six conductance bits set driver conductance.
// - Pulse lasts two times width plus one.
// - Two-bit gain code selects 20/24/31/35 dB.
// - Single-frame mode stops receiver after frame.
// - Bits after collision forced to zero.
// - Decode 11h-17h and 19h-1Ah register pages.
module rftx_regs #(
  parameter int ADDR_W = 6, // Host address width.
  parameter int DATA_W = 8 // Host data width.
) (
  input wire logic sys_clk, // Device clock, 40 MHz.
  input wire logic rst, // Asynchronous reset, active high.
  input wire logic host_wr, // Host write strobe, one cycle.
  input wire logic host_rd, // Host read strobe, one cycle.
  input wire logic [ADDR_W-1:0] host_addr, // Host register address.
  input wire logic [DATA_W-1:0] host_wdata, // Host write data.
  output logic [DATA_W-1:0] host_rdata, // Read data, held until next read.
  input wire logic carrier_in, // Carrier level from the oscillator logic.
  input wire logic encoder_bit, // Internal encoder output.
  input wire logic ext_modulation_in, // External modulation pin.
  output logic antenna_drive_1, // First antenna driver output.
  output logic antenna_drive_2, // Second antenna driver output.
  output logic mod_pulse_out, // Modulation pulse in progress.
  output logic [5:0] driver_conductance_value, // Driver conductance.
  output logic [1:0] rx_gain_code, // Receiver gain code.
  output logic [5:0] rx_gain_db, // Receiver gain in dB.
  input wire logic rx_start, // Receiver start request, one cycle.
  input wire logic rx_frame_end, // Frame received, one cycle.
  input wire logic rx_bit_valid, // Received bit strobe.
  input wire logic rx_bit_in, // Received bit value.
  input wire logic rx_collision, // Collision on this bit.
  output logic rx_enable, // Receiver active.
  output logic rx_bit_out_valid, // Decoded bit strobe.
  output logic rx_bit_out // Decoded bit, masked after a collision.
);

  // The data path assumes byte-wide registers and a six-bit address.
  if (ADDR_W != 6 || DATA_W != 8)
  begin : g_bus_check
    $error("rftx_regs: ADDR_W must be 6 and DATA_W 8");
  end

  // Gain code to dB, kept as one table.
  function automatic logic [5:0] gain_to_db(input logic [1:0] code);
    logic [5:0] db;
    case (code)
      2'b00: db = rftx_pkg::GAIN_DB_CODE0;
      2'b01: db = rftx_pkg::GAIN_DB_CODE1;
      2'b10: db = rftx_pkg::GAIN_DB_CODE2;
      default: db = rftx_pkg::GAIN_DB_CODE3;
    endcase
    return db;
  endfunction

  // Register file storage.
  logic [7:0] tx_pin_control_r; // Driver pin control.
  logic [7:0] tx_pin_control_nxt;
  logic [7:0] driver_conductance_r; // Driver conductance.
  logic [7:0] driver_conductance_nxt;
  logic [7:0] fixed_setting_a_r; // Fixed settings, stored as written.
  logic [7:0] fixed_setting_a_nxt;
  logic [7:0] fixed_setting_b_r;
  logic [7:0] fixed_setting_b_nxt;
  logic [7:0] pulse_width_r; // Modulation pulse width.
  logic [7:0] pulse_width_nxt;
  logic [7:0] fixed_setting_c_r;
  logic [7:0] fixed_setting_c_nxt;
  logic [7:0] fixed_setting_d_r;
  logic [7:0] fixed_setting_d_nxt;
  logic [7:0] receiver_gain_control_r; // Receiver gain.
  logic [7:0] receiver_gain_control_nxt;
  logic [7:0] decoder_behaviour_r; // Decoder behaviour.
  logic [7:0] decoder_behaviour_nxt;
  logic [7:0] host_rdata_r; // Registered read data.
  logic [7:0] host_rdata_nxt;

  // Host write decode. Fixed bits are stored as written; keeping them
  // at their set values is the host's job, and software reads back
  // exactly what it wrote.
  always_comb
  begin
    tx_pin_control_nxt = tx_pin_control_r;
    driver_conductance_nxt = driver_conductance_r;
    fixed_setting_a_nxt = fixed_setting_a_r;
    fixed_setting_b_nxt = fixed_setting_b_r;
    pulse_width_nxt = pulse_width_r;
    fixed_setting_c_nxt = fixed_setting_c_r;
    fixed_setting_d_nxt = fixed_setting_d_r;
    receiver_gain_control_nxt = receiver_gain_control_r;
    decoder_behaviour_nxt = decoder_behaviour_r;
    if (host_wr)
    begin
      if (host_addr == rftx_pkg::ADDR_TX_PIN_CONTROL)
        tx_pin_control_nxt = host_wdata;
      else if (host_addr == rftx_pkg::ADDR_DRIVER_CONDUCTANCE)
        driver_conductance_nxt = host_wdata;
      else if (host_addr == rftx_pkg::ADDR_FIXED_SETTING_A)
        fixed_setting_a_nxt = host_wdata;
      else if (host_addr == rftx_pkg::ADDR_FIXED_SETTING_B)
        fixed_setting_b_nxt = host_wdata;
      else if (host_addr == rftx_pkg::ADDR_PULSE_WIDTH)
        pulse_width_nxt = host_wdata;
      else if (host_addr == rftx_pkg::ADDR_FIXED_SETTING_C)
        fixed_setting_c_nxt = host_wdata;
      else if (host_addr == rftx_pkg::ADDR_FIXED_SETTING_D)
        fixed_setting_d_nxt = host_wdata;
      else if (host_addr == rftx_pkg::ADDR_RECEIVER_GAIN_CONTROL)
        receiver_gain_control_nxt = host_wdata;
      else if (host_addr == rftx_pkg::ADDR_DECODER_BEHAVIOUR)
        decoder_behaviour_nxt = host_wdata;
      // Writes to any other address are dropped without effect.
    end
  end

  // Host read decode. Unmapped addresses, including 18h, read as zero.
  always_comb
  begin
    host_rdata_nxt = host_rdata_r;
    if (host_rd)
    begin
      if (host_addr == rftx_pkg::ADDR_TX_PIN_CONTROL)
        host_rdata_nxt = tx_pin_control_r;
      else if (host_addr == rftx_pkg::ADDR_DRIVER_CONDUCTANCE)
        host_rdata_nxt = driver_conductance_r;
      else if (host_addr == rftx_pkg::ADDR_FIXED_SETTING_A)
        host_rdata_nxt = fixed_setting_a_r;
      else if (host_addr == rftx_pkg::ADDR_FIXED_SETTING_B)
        host_rdata_nxt = fixed_setting_b_r;
      else if (host_addr == rftx_pkg::ADDR_PULSE_WIDTH)
        host_rdata_nxt = pulse_width_r;
      else if (host_addr == rftx_pkg::ADDR_FIXED_SETTING_C)
        host_rdata_nxt = fixed_setting_c_r;
      else if (host_addr == rftx_pkg::ADDR_FIXED_SETTING_D)
        host_rdata_nxt = fixed_setting_d_r;
      else if (host_addr == rftx_pkg::ADDR_RECEIVER_GAIN_CONTROL)
        host_rdata_nxt = receiver_gain_control_r;
      else if (host_addr == rftx_pkg::ADDR_DECODER_BEHAVIOUR)
        host_rdata_nxt = decoder_behaviour_r;
      else
        host_rdata_nxt = 8'h00;
    end
  end

  // Register file flip-flops.
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      tx_pin_control_r <= rftx_pkg::RST_TX_PIN_CONTROL;
      driver_conductance_r <= rftx_pkg::RST_DRIVER_CONDUCTANCE;
      fixed_setting_a_r <= rftx_pkg::RST_FIXED_SETTING_A;
      fixed_setting_b_r <= rftx_pkg::RST_FIXED_SETTING_B;
      pulse_width_r <= rftx_pkg::RST_PULSE_WIDTH;
      fixed_setting_c_r <= rftx_pkg::RST_FIXED_SETTING_C;
      fixed_setting_d_r <= rftx_pkg::RST_FIXED_SETTING_D;
      receiver_gain_control_r <= rftx_pkg::RST_RECEIVER_GAIN_CONTROL;
      decoder_behaviour_r <= rftx_pkg::RST_DECODER_BEHAVIOUR;
      host_rdata_r <= 8'h00;
    end
    else
    begin
      tx_pin_control_r <= tx_pin_control_nxt;
      driver_conductance_r <= driver_conductance_nxt;
      fixed_setting_a_r <= fixed_setting_a_nxt;
      fixed_setting_b_r <= fixed_setting_b_nxt;
      pulse_width_r <= pulse_width_nxt;
      fixed_setting_c_r <= fixed_setting_c_nxt;
      fixed_setting_d_r <= fixed_setting_d_nxt;
      receiver_gain_control_r <= receiver_gain_control_nxt;
      decoder_behaviour_r <= decoder_behaviour_nxt;
      host_rdata_r <= host_rdata_nxt;
    end
  end

  // Fields pulled out of the control registers.
  rftx_pkg::rftx_mod_sel_t mod_input_select; // Modulator source.
  logic drv2_invert; // Invert carrier on driver two.
  logic drv2_unmodulated; // Plain carrier on driver two.
  logic drv2_rf_on; // Driver two carries RF.
  logic drv1_rf_on; // Driver one carries RF.
  logic multi_frame_rx; // Keep receiving after one frame.
  logic mask_after_collision; // Zero bits after a collision.

  assign mod_input_select = rftx_pkg::rftx_mod_sel_t'(
    tx_pin_control_r[rftx_pkg::TXC_MOD_SEL_LSB +: 2]);
  assign drv2_invert = tx_pin_control_r[rftx_pkg::TXC_DRV2_INVERT];
  assign drv2_unmodulated = tx_pin_control_r[rftx_pkg::TXC_DRV2_UNMOD];
  assign drv2_rf_on = tx_pin_control_r[rftx_pkg::TXC_DRV2_RF_ON];
  assign drv1_rf_on = tx_pin_control_r[rftx_pkg::TXC_DRV1_RF_ON];
  assign multi_frame_rx = decoder_behaviour_r[rftx_pkg::DEC_MULTI_FRAME];
  assign mask_after_collision =
    decoder_behaviour_r[rftx_pkg::DEC_MASK_AFTER_COLL];

  // The external modulation pin is asynchronous to the device clock, so it
  // passes two flip-flops; only the second is read by the selector.
  logic ext_sync1_r; // First synchroniser stage.
  logic ext_sync2_r; // Second synchroniser stage.
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      ext_sync1_r <= 1'b0;
      ext_sync2_r <= 1'b0;
    end
    else
    begin
      ext_sync1_r <= ext_modulation_in;
      ext_sync2_r <= ext_sync1_r;
    end
  end

  // Modulator input selection.
  logic mod_level; // Selected modulator input.
  always_comb
  begin
    case (mod_input_select)
      rftx_pkg::RFTX_MOD_LOW: mod_level = 1'b0;
      rftx_pkg::RFTX_MOD_HIGH: mod_level = 1'b1;
      rftx_pkg::RFTX_MOD_ENCODER: mod_level = encoder_bit;
      default: mod_level = ext_sync2_r;
    endcase
  end

  // A rising edge of the modulator input while no pulse is running starts one timed pulse.
  logic mod_pulse; // Pulse from the generator.
  rftx_pulse_gen #(
    .WIDTH_W(8)
  ) u_pulse_gen (
    .sys_clk(sys_clk),
    .rst(rst),
    .mod_level(mod_level),
    .width_value(pulse_width_r),
    .pulse(mod_pulse)
  );

  // Driver outputs. The pulse blanks the carrier (full-depth keying).
  // Disabled drivers hold a constant low level.
  logic drive1_nxt; // Next level of driver one.
  logic drive2_nxt; // Next level of driver two.
  logic drive2_base; // Driver two before the optional inversion.
  always_comb
  begin
    drive1_nxt = 1'b0;
    drive2_nxt = 1'b0;
    drive2_base = carrier_in & ~mod_pulse;
    if (drv1_rf_on)
      drive1_nxt = carrier_in & ~mod_pulse;
    if (drv2_unmodulated)
      drive2_base = carrier_in;
    if (drv2_rf_on)
    begin
      if (drv2_invert)
        drive2_nxt = ~drive2_base;
      else
        drive2_nxt = drive2_base;
    end
    // A disabled driver two stays low whatever the invert bit says.
  end

  logic drive1_r; // Driver one output flop.
  logic drive2_r; // Driver two output flop.
  logic mod_pulse_r; // Pulse output flop.
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      drive1_r <= 1'b0;
      drive2_r <= 1'b0;
      mod_pulse_r <= 1'b0;
    end
    else
    begin
      drive1_r <= drive1_nxt;
      drive2_r <= drive2_nxt;
      mod_pulse_r <= mod_pulse;
    end
  end

  // Receiver state: single-frame mode drops out after each frame end.
  rftx_pkg::rftx_rx_state_t rx_state_r; // Receiver activity.
  rftx_pkg::rftx_rx_state_t rx_state_nxt;
  logic coll_seen_r; // A collision has been seen in this reception.
  logic coll_seen_nxt;
  logic rx_bit_out_r; // Decoded bit.
  logic rx_bit_out_nxt;
  logic rx_bit_out_valid_r; // Decoded bit strobe.
  logic rx_bit_out_valid_nxt;
  logic [5:0] rx_gain_db_r; // Gain in dB.
  logic [5:0] rx_gain_db_nxt;

  always_comb
  begin
    rx_state_nxt = rx_state_r;
    coll_seen_nxt = coll_seen_r;
    rx_bit_out_nxt = rx_bit_out_r;
    rx_bit_out_valid_nxt = 1'b0;
    rx_gain_db_nxt = gain_to_db(
      receiver_gain_control_r[rftx_pkg::GAIN_CODE_LSB +: 2]);
    case (rx_state_r)
      rftx_pkg::RFTX_RX_IDLE:
      begin
        if (rx_start)
          rx_state_nxt = rftx_pkg::RFTX_RX_ACTIVE;
      end
      default:
      begin
        if (rx_frame_end && !multi_frame_rx)
          rx_state_nxt = rftx_pkg::RFTX_RX_IDLE;
      end
    endcase
    // A new start clears the collision history; a collision in the same
    // cycle still wins so it is never lost.
    if (rx_start)
      coll_seen_nxt = 1'b0;
    if (rx_bit_valid && rx_state_r == rftx_pkg::RFTX_RX_ACTIVE)
    begin
      rx_bit_out_valid_nxt = 1'b1;
      // The colliding bit itself is passed; only later bits are masked.
      if (mask_after_collision && coll_seen_r)
        rx_bit_out_nxt = 1'b0;
      else
        rx_bit_out_nxt = rx_bit_in;
      if (rx_collision)
        coll_seen_nxt = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      rx_state_r <= rftx_pkg::RFTX_RX_IDLE;
      coll_seen_r <= 1'b0;
      rx_bit_out_r <= 1'b0;
      rx_bit_out_valid_r <= 1'b0;
      rx_gain_db_r <= rftx_pkg::GAIN_DB_CODE3;
    end
    else
    begin
      rx_state_r <= rx_state_nxt;
      coll_seen_r <= coll_seen_nxt;
      rx_bit_out_r <= rx_bit_out_nxt;
      rx_bit_out_valid_r <= rx_bit_out_valid_nxt;
      rx_gain_db_r <= rx_gain_db_nxt;
    end
  end

  // Outputs, each straight from a flip-flop.
  assign host_rdata = host_rdata_r;
  assign antenna_drive_1 = drive1_r;
  assign antenna_drive_2 = drive2_r;
  assign mod_pulse_out = mod_pulse_r;
  assign driver_conductance_value =
    driver_conductance_r[rftx_pkg::COND_VALUE_LSB +: 6];
  assign rx_gain_code =
    receiver_gain_control_r[rftx_pkg::GAIN_CODE_LSB +: 2];
  assign rx_gain_db = rx_gain_db_r;
  assign rx_enable = (rx_state_r == rftx_pkg::RFTX_RX_ACTIVE);
  assign rx_bit_out_valid = rx_bit_out_valid_r;
  assign rx_bit_out = rx_bit_out_r;

endmodule

`default_nettype wire

// file: test/rftx_regs_asserts.sv
`timescale 1ns/100ps
`default_nettype none
// Port-level checker; mirrors the needed registers from host writes.
module rftx_regs_asserts (
  input wire logic sys_clk, // Clock.
  input wire logic rst, // Reset.
  input wire logic host_wr, // Write strobe.
  input wire logic host_rd, // Read strobe.
  input wire logic [5:0] host_addr, // Address.
  input wire logic [7:0] host_wdata, // Write data.
  input wire logic [7:0] host_rdata, // Read data.
  input wire logic antenna_drive_1, // Driver one.
  input wire logic antenna_drive_2, // Driver two.
  input wire logic mod_pulse_out, // Pulse.
  input wire logic [5:0] driver_conductance_value, // Conductance.
  input wire logic [1:0] rx_gain_code, // Gain code.
  input wire logic [5:0] rx_gain_db, // Gain in dB.
  input wire logic rx_start, // Receiver start.
  input wire logic rx_frame_end, // Frame end.
  input wire logic rx_bit_valid, // Bit strobe.
  input wire logic rx_collision, // Collision.
  input wire logic rx_enable, // Receiver on.
  input wire logic rx_bit_out_valid, // Bit out strobe.
  input wire logic rx_bit_out // Bit out.
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  logic [7:0] tx_r, tx_nxt, cd_r, cd_nxt, pw_r, pw_nxt, dc_r, dc_nxt; // Mirrors.
  logic [9:0] pc_r, pc_nxt; // Cycles the pulse has stood high.
  logic [5:0] db_exp; // Gain in dB for the present code.
  logic mapped; // Address decodes to a register.
  // Mirrors take a write at the same edge as the real registers do.
  always_comb
  begin
    tx_nxt = host_wr && host_addr == 6'h11 ? host_wdata : tx_r;
    cd_nxt = host_wr && host_addr == 6'h12 ? host_wdata : cd_r;
    pw_nxt = host_wr && host_addr == 6'h15 ? host_wdata : pw_r;
    dc_nxt = host_wr && host_addr == 6'h1A ? host_wdata : dc_r;
    pc_nxt = mod_pulse_out ? pc_r + 10'h001 : 10'h000;
    mapped = host_addr inside {[6'h11:6'h17], 6'h19, 6'h1A};
    db_exp = rx_gain_code[1] ? (rx_gain_code[0] ? 6'h23 : 6'h1F)
      : (rx_gain_code[0] ? 6'h18 : 6'h14);
  end
  // Registers the mirrors and the pulse counter.
  always_ff @(posedge sys_clk or posedge rst)
    if (rst)
      {tx_r, cd_r, pw_r, dc_r, pc_r} <= {32'h583F1308, 10'h000};
    else
      {tx_r, cd_r, pw_r, dc_r, pc_r} <= {tx_nxt, cd_nxt, pw_nxt, dc_nxt, pc_nxt};
  // A collision, then the next bit of the same reception.
  sequence s_coll;
    rx_bit_valid && rx_enable && rx_collision;
  endsequence
  sequence s_later_bit;
    rx_bit_valid && rx_enable && !rx_start && dc_r[5];
  endsequence
  AST_RD_UNMAPPED: assert property (
    host_rd && !mapped |=> host_rdata == 8'h00)
    else $error("unmapped read not zero");
  AST_COND: assert property (
    $past(cd_r) == cd_r && $past(cd_r, 2) == cd_r
    |-> driver_conductance_value == cd_r[5:0])
    else $error("conductance output differs");
  AST_GAIN_DB: assert property (rx_gain_db == $past(db_exp))
    else $error("gain in dB wrong");
  AST_DRV1_OFF: assert property (
    !tx_r[0] && !$past(tx_r[0]) |-> !antenna_drive_1)
    else $error("driver one not constant");
  AST_DRV2_OFF: assert property (
    !tx_r[1] && !$past(tx_r[1]) |-> !antenna_drive_2)
    else $error("driver two not constant");
  AST_PULSE: assert property (
    $fell(mod_pulse_out) |-> pc_r == {1'b0, pw_r, 1'b0} + 10'h002)
    else $error("pulse length wrong");
  AST_RX_STOP: assert property (
    rx_frame_end && rx_enable && !rx_start && !dc_r[6] |=> !rx_enable)
    else $error("receiver still on");
  AST_BIT_STROBE: assert property (
    rx_bit_out_valid == ($past(rx_bit_valid) && $past(rx_enable)))
    else $error("decoded strobe wrong");
  AST_MASK: assert property (s_coll ##1 s_later_bit |=> !rx_bit_out)
    else $error("bit after collision not zero");
endmodule

bind rftx_regs rftx_regs_asserts u_chk (.*);
`default_nettype wire

// file: test/rftx_card_model.sv
`timescale 1ns/100ps
`default_nettype none
// Card beyond the field: after go it sends eight bits, one a cycle,
// and flags a collision on one of them.
module rftx_card_model (
  input wire logic sys_clk, // Clock.
  input wire logic go, // Send one frame.
  input wire logic [7:0] bits, // Frame bits, first in bit 0.
  input wire logic [2:0] cpos, // Bit that collides.
  output logic valid, // Bit strobe.
  output logic bit_v, // Bit value.
  output logic coll, // Collision flag.
  output logic fend // End of frame.
);
  int idx = 9; // Next bit to send; 9 means silent.
  initial
  begin
    {valid, bit_v, coll, fend} = 4'h0;
  end
  // A request is seen on the rising edge, answered from the falling one.
  always @(posedge sys_clk)
    if (go)
      idx = 0;
  // Between frames the data line toggles, so a stale level never passes
  // for a real bit.
  always @(negedge sys_clk)
  begin
    valid <= idx < 8;
    bit_v <= idx < 8 ? bits[idx[2:0]] : ~bit_v;
    coll <= idx < 8 && idx == int'(cpos);
    fend <= idx == 8;
    if (idx < 9)
      idx = idx + 1;
  end
endmodule
`default_nettype wire

// file: test/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
// Host, modulation source and receiver; reads and decoded bits are
// judged against queues of expectations.
module tb_top;
  logic sys_clk, rst, host_wr, host_rd, carrier_in, encoder_bit, go;
  logic ext_modulation_in, rx_start, rx_frame_end, rx_bit_valid, rx_bit_in;
  logic rx_collision, rx_enable, rx_bit_out_valid, rx_bit_out, mod_pulse_out;
  logic antenna_drive_1, antenna_drive_2;
  logic rd_due = 1'b0; // A read answer is due at this edge.
  logic [5:0] host_addr, driver_conductance_value, rx_gain_db;
  logic [7:0] host_wdata, host_rdata, bits, w, d;
  logic [2:0] cpos;
  logic [1:0] rx_gain_code;
  logic [31:0] rs = 32'h00007476; // Random state.
  logic [7:0] rd_q[$]; // Expected read data.
  logic [7:0] bit_q[$]; // Expected decoded bits.
  int bad_count = 0;
  int checks_done = 0;
  int cnt;
  // Mapped places with their reset values, then three unmapped ones.
  logic [5:0] ra[12] = '{6'h11, 6'h12, 6'h13, 6'h14, 6'h15, 6'h16, 6'h17,
    6'h19, 6'h1A, 6'h10, 6'h18, 6'h1B};
  logic [7:0] rv[12] = '{8'h58, 8'h3F, 8'h3F, 8'h19, 8'h13, 8'h00, 8'h00,
    8'h73, 8'h08, 8'h00, 8'h00, 8'h00};
  logic [7:0] db[4] = '{8'h14, 8'h18, 8'h1F, 8'h23}; // Gain in dB by code.

  rftx_regs DUT (.*);
  rftx_card_model card (.sys_clk, .go, .bits, .cpos, .valid(rx_bit_valid),
    .bit_v(rx_bit_in), .coll(rx_collision), .fend(rx_frame_end));

  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  function automatic logic [31:0] xs();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction

  task automatic check(string nm, logic [7:0] seen, logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Bus tasks wait an edge first, so strobes never rise twice at once.
  task automatic wr(logic [5:0] a, logic [7:0] v);
    @(negedge sys_clk);
    host_wr = 1'b1;
    host_addr = a;
    host_wdata = v;
    @(negedge sys_clk);
    host_wr = 1'b0;
  endtask

  task automatic rd(logic [5:0] a, logic [7:0] e);
    @(negedge sys_clk);
    host_rd = 1'b1;
    host_addr = a;
    rd_q.push_back(e);
    @(negedge sys_clk);
    host_rd = 1'b0;
  endtask

  task automatic do_reset();
    rst = 1'b1;
    repeat (3) @(negedge sys_clk);
    rst = 1'b0;
  endtask

  // One frame from the card; bits after a collision are expected as zero.
  task automatic send(logic on, logic all, logic mask);
    bits = 8'(xs());
    cpos = 3'(xs());
    for (int i = 0; i < 8; i++)
      if (on)
        bit_q.push_back(mask && (all || i > cpos) ? 8'h00 : 8'(bits[i]));
    go = 1'b1;
    @(negedge sys_clk);
    go = 1'b0;
    repeat (12) @(negedge sys_clk);
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // An unexpected decoded bit meets an impossible expectation.
  always @(posedge sys_clk)
  begin
    if (rd_due)
      check("rdata", host_rdata, rd_q.pop_front());
    if (rx_bit_out_valid === 1'b1)
      check("rx bit", 8'(rx_bit_out),
        bit_q.size() > 0 ? bit_q.pop_front() : 8'hFF);
    rd_due <= host_rd;
  end

  // About 370 cycles are needed; 5000 means a hang.
  initial
  begin
    #(25 * 5000);
    bad_count++;
    test_done();
  end

  initial
  begin
    {host_wr, host_rd, encoder_bit, ext_modulation_in, rx_start, go} = '0;
    {host_addr, host_wdata, bits, cpos, w, d} = '0;
    carrier_in = 1'b1;
    do_reset();
    foreach (ra[i])
      rd(ra[i], rv[i]);
    check("cond", 8'(driver_conductance_value), 8'h3F);
    check("gain", 8'(rx_gain_db), 8'h23);
    wr(6'h18, 8'hA5);
    rd(6'h18, 8'h00);
    d = 8'(xs()) & 8'h3F;
    wr(6'h12, d);
    rd(6'h12, d);
    check("cond", 8'(driver_conductance_value), d);
    for (int g = 0; g < 4; g++)
    begin
      wr(6'h19, 8'h70 | 8'(g));
      repeat (3) @(negedge sys_clk);
      check("gain db", 8'(rx_gain_db), db[g]);
    end
    // Every selector code, each with its own invert and plain-carrier mix.
    for (int s = 0; s < 4; s++)
    begin
      w = 8'(xs()) & 8'h0F;
      wr(6'h11, 8'h13);
      {encoder_bit, ext_modulation_in} = 2'b00;
      wr(6'h15, w);
      wr(6'h11, {1'b0, s[1], s[0], 1'b1, s[0], s[1], 2'b11});
      {encoder_bit, ext_modulation_in} = {s == 2, s == 3};
      cnt = 0;
      repeat (40)
      begin
        @(negedge sys_clk);
        cnt += int'(mod_pulse_out);
        if (cnt == w + 1 && mod_pulse_out)
        begin
          check("drv1 mid", 8'(antenna_drive_1), 8'h00);
          check("drv2 mid", 8'(antenna_drive_2), 8'(s[1] ^ s[0]));
        end
      end
      check("pulse", 8'(cnt), s > 0 ? 8'(2 * (w + 1)) : 8'h00);
      check("drv1", 8'(antenna_drive_1), 8'h01);
      check("drv2", 8'(antenna_drive_2), 8'(!s[0]));
    end
    wr(6'h11, 8'h18);
    repeat (3) @(negedge sys_clk);
    check("drv1 off", 8'(antenna_drive_1), 8'h00);
    check("drv2 off", 8'(antenna_drive_2), 8'h00);
    // Each decoder mode starts from a fresh reset.
    for (int m = 0; m < 4; m++)
    begin
      do_reset();
      wr(6'h1A, {1'b0, m[1], m[0], 5'h08});
      rx_start = 1'b1;
      @(negedge sys_clk);
      rx_start = 1'b0;
      check("rx on", 8'(rx_enable), 8'h01);
      send(1'b1, 1'b0, m[0]);
      check("rx after", 8'(rx_enable), 8'(m[1]));
      send(m[1], 1'b1, m[0]);
    end
    check("left", 8'(bit_q.size()), 8'h00);
    test_done();
  end
endmodule
`default_nettype wire
